// ---- logic/mvip_pkg.sv ----
// Function
// - Three levels with nested servicing.
// - Highest above high above low.
// - Refuse requests at or below service level.
// - Simultaneous requests: highest level wins.
// - Equal level: smallest vector address wins.
// - Twenty-eight sources onto ten vectors.
// - Vector 00013H shared by five sources.
// - Vector 00033H shared by four sources.
package mvip_pkg;

  localparam int unsigned NUM_SRC = 28;
  localparam int unsigned NUM_VEC = 10;
  localparam int unsigned VEC_IDX_W = 4;
  localparam int unsigned VEC_ADDR_W = 17;
  localparam int unsigned NEST_DEPTH = 3;

  // Levels are ordered so that a numeric compare gives the priority order.
  typedef enum logic [1:0] {
    MVIP_LVL_NONE = 2'h0,
    MVIP_LVL_LOW = 2'h1,
    MVIP_LVL_HIGH = 2'h2,
    MVIP_LVL_HIGHEST = 2'h3
  } mvip_level_e;

  // Vector base and spacing: vector n sits at 00003H + 8 * n.
  localparam logic [VEC_ADDR_W-1:0] VEC_BASE = 17'h00003;
  localparam logic [VEC_ADDR_W-1:0] VEC_STEP = 17'h00008;
  localparam logic [VEC_ADDR_W-1:0] VEC_THIRD_ADDR = 17'h00013;
  localparam logic [VEC_ADDR_W-1:0] VEC_SEVENTH_ADDR = 17'h00033;

  // Source bit positions.
  localparam int unsigned SRC_EXT0 = 0;
  localparam int unsigned SRC_EXT1 = 1;
  localparam int unsigned SRC_EXT2 = 2;
  localparam int unsigned SRC_T0L = 3;
  localparam int unsigned SRC_EXT4 = 4;
  localparam int unsigned SRC_USB_ACTIVE = 5;
  localparam int unsigned SRC_REMOTE_RX = 6;
  localparam int unsigned SRC_EXT3 = 7;
  localparam int unsigned SRC_EXT5 = 8;
  localparam int unsigned SRC_BASE_TIMER = 9;
  localparam int unsigned SRC_T0H = 10;
  localparam int unsigned SRC_T1L = 11;
  localparam int unsigned SRC_T1H = 12;
  localparam int unsigned SRC_SYNC0 = 13;
  localparam int unsigned SRC_USB_RESET = 14;
  localparam int unsigned SRC_USB_SUSPEND = 15;
  localparam int unsigned SRC_ASYNC_RX = 16;
  localparam int unsigned SRC_SERIAL1 = 17;
  localparam int unsigned SRC_USB_EP = 18;
  localparam int unsigned SRC_USB_SOF = 19;
  localparam int unsigned SRC_SYNC4 = 20;
  localparam int unsigned SRC_ASYNC_TX = 21;
  localparam int unsigned SRC_ADC = 22;
  localparam int unsigned SRC_T6 = 23;
  localparam int unsigned SRC_T7 = 24;
  localparam int unsigned SRC_PORT0 = 25;
  localparam int unsigned SRC_PWM0 = 26;
  localparam int unsigned SRC_PWM1 = 27;

  // Vector each source belongs to, indexed by source bit.
  localparam logic [NUM_SRC*VEC_IDX_W-1:0] SRC_TO_VEC = {
    4'h9, 4'h9, 4'h9, 4'h8, 4'h8, 4'h8,
    4'h7, 4'h7, 4'h7, 4'h7, 4'h7,
    4'h6, 4'h6, 4'h6, 4'h6,
    4'h5, 4'h5, 4'h4,
    4'h3, 4'h3, 4'h3,
    4'h2, 4'h2, 4'h2, 4'h2, 4'h2,
    4'h1, 4'h0
  };

  // Vectors 0 and 1 may be highest or low; the rest high or low.
  localparam logic [NUM_VEC-1:0] VEC_UPPER_IS_HIGHEST = 10'h003;

  // Request from the core side: take the offered vector or return from service.
  typedef struct packed {
    logic take;
    logic ret;
  } mvip_core_s;

  // Grant offered to the core.
  typedef struct packed {
    logic req;
    logic [VEC_IDX_W-1:0] idx;
    logic [VEC_ADDR_W-1:0] addr;
    mvip_level_e level;
  } mvip_grant_s;

endpackage : mvip_pkg

// ---- logic/mvip_ctrl.sv ----
`timescale 1ns/1ps
module mvip_ctrl
  import mvip_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [NUM_SRC-1:0] src_event,
  input wire logic [NUM_SRC-1:0] src_clear,
  input wire logic [NUM_VEC-1:0] vec_level_upper,
  input wire logic [NUM_VEC-1:0] vec_enable,
  input wire mvip_core_s core,
  output mvip_grant_s grant,
  output logic [NUM_SRC-1:0] src_pending,
  output mvip_level_e service_level
);

  // Whole state: pending flags, nesting stack of levels, and depth.
  typedef struct packed {
    logic [NUM_SRC-1:0] pend;
    logic [NEST_DEPTH*2-1:0] stack;
    logic [1:0] depth;
  } mvip_state_s;

  mvip_state_s st;
  mvip_state_s next_st;
  logic [NUM_VEC-1:0] vec_req;
  mvip_level_e vec_lvl [NUM_VEC];
  mvip_level_e cur_lvl;
  mvip_grant_s cand;

  // Gather sources onto their shared vectors and give each its level.
  genvar v;
  generate
    for (v = 0; v < NUM_VEC; v++) begin : g_vec
      logic [NUM_SRC-1:0] member;
      genvar s;
      for (s = 0; s < NUM_SRC; s++) begin : g_src
        assign member[s] = (SRC_TO_VEC[s*VEC_IDX_W +: VEC_IDX_W] == VEC_IDX_W'(v));
      end
      // Third and seventh vectors collect their listed sources here.
      assign vec_req[v] = vec_enable[v] && |(st.pend & member);
      assign vec_lvl[v] = !vec_level_upper[v] ? MVIP_LVL_LOW :
                          VEC_UPPER_IS_HIGHEST[v] ? MVIP_LVL_HIGHEST : MVIP_LVL_HIGH;
    end
  endgenerate

  // Current acceptance threshold is the top of the nesting stack.
  assign cur_lvl = (st.depth == 2'h0) ? MVIP_LVL_NONE :
                   mvip_level_e'(st.stack[(st.depth - 2'h1)*2 +: 2]);

  // Pick the highest level, ties to the lowest vector, above the threshold.
  always_comb begin
    cand = '0;
    cand.level = MVIP_LVL_NONE;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      if (vec_req[i] && vec_lvl[i] > cur_lvl && vec_lvl[i] >= cand.level) begin
        cand.req = 1'b1; // Scanning downward lets the smaller vector win a tie.
        cand.idx = VEC_IDX_W'(i);
        cand.level = vec_lvl[i];
      end
    end
    cand.addr = VEC_BASE + VEC_STEP * VEC_ADDR_W'(cand.idx);
  end

  // Next-state: pending flags set-wins-over-clear, stack push on take, pop on return.
  always_comb begin
    next_st = st;
    next_st.pend = (st.pend & ~src_clear) | src_event;
    if (core.take && cand.req) begin
      for (int s = 0; s < NUM_SRC; s++) begin
        if (SRC_TO_VEC[s*VEC_IDX_W +: VEC_IDX_W] == cand.idx && !src_event[s]) begin
          next_st.pend[s] = 1'b0; // Taking the vector retires its sources, except any with a new event in the same cycle.
        end
      end
      if (st.depth != 2'(NEST_DEPTH)) begin
        next_st.stack[st.depth*2 +: 2] = cand.level;
        next_st.depth = st.depth + 2'h1;
      end
    end else if (core.ret && st.depth != 2'h0) begin
      next_st.depth = st.depth - 2'h1; // Restore previous threshold.
    end
  end

  // State register.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign grant = cand;
  assign src_pending = st.pend;
  assign service_level = cur_lvl;

endmodule : mvip_ctrl

// ---- bench/mvip_ctrl_assertions.sv ----
`timescale 1ns/1ps
module mvip_chk
  import mvip_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [NUM_SRC-1:0] src_event,
  input wire logic [NUM_SRC-1:0] src_clear,
  input wire logic [NUM_VEC-1:0] vec_level_upper,
  input wire logic [NUM_VEC-1:0] vec_enable,
  input wire mvip_core_s core,
  input wire mvip_grant_s grant,
  input wire logic [NUM_SRC-1:0] src_pending,
  input wire mvip_level_e service_level
);
  logic [1:0] top;
  logic [1:0] l;
  logic [3:0] win;
  logic [3:0] v;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Finds the best pending level; scanning downwards lets ties fall to the smaller vector.
  always_comb begin
    top = 2'h0;
    win = 4'h0;
    v = 4'h0;
    l = 2'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      v = SRC_TO_VEC[i*4+:4];
      l = !vec_enable[v] ? 2'h0 : !vec_level_upper[v] ? 2'h1 : VEC_UPPER_IS_HIGHEST[v] ? 2'h3 : 2'h2;
      if (src_pending[i] && l != 2'h0 && l >= top) begin
        top = l;
        win = v;
      end
    end
  end
  a_pick_best: assert property (grant.req |-> grant.level == top && grant.idx == win)
    else $error("wrong vector chosen");
  a_offer_gate: assert property (grant.req == (top > service_level))
    else $error("offer ignores service level");
  a_vec_addr: assert property (grant.req |-> grant.addr == VEC_BASE + VEC_STEP * grant.idx)
    else $error("vector address wrong");
  a_third_addr: assert property (grant.req && grant.idx == 4'h2 |-> grant.addr == VEC_THIRD_ADDR)
    else $error("third vector address wrong");
  a_seventh_addr: assert property (grant.req && grant.idx == 4'h6 |-> grant.addr == VEC_SEVENTH_ADDR)
    else $error("seventh vector address wrong");
  a_take_push: assert property (grant.req && core.take |=> service_level == $past(grant.level))
    else $error("take did not raise level");
  a_ret_pop: assert property (core.ret && !core.take && service_level != 0 |=> service_level < $past(service_level))
    else $error("return did not lower level");
  a_pend_hold: assert property (!core.take |=> ($past(src_pending) & ~$past(src_clear) & ~src_pending) == '0)
    else $error("pending request lost");
  c_take: cover property (grant.req && core.take);
  c_deep: cover property (service_level == MVIP_LVL_HIGHEST);
  c_seventh: cover property (grant.req && grant.idx == 4'h6);
endmodule : mvip_chk
bind mvip_ctrl mvip_chk i_chk (.*);

// ---- bench/mvip_core_model.sv ----
`timescale 1ns/1ps
module mvip_core_model
  import mvip_pkg::*;
(
  input wire mvip_grant_s grant,
  input wire logic accept,
  input wire logic leave,
  output mvip_core_s core
);
  // The core takes whatever is offered while allowed and returns on command.
  assign core = '{take: accept & grant.req, ret: leave};
endmodule : mvip_core_model

// ---- bench/tb_mvip_ctrl.sv ----
`timescale 1ns/1ps
module tb_mvip_ctrl;
  import mvip_pkg::*;
  logic clk_sys = 0, resetn = 0, accept = 0, leave = 0;
  logic [NUM_SRC-1:0] src_event = '0, src_clear = '0, src_pending;
  logic [NUM_VEC-1:0] vec_level_upper = '0, vec_enable = '1;
  mvip_core_s core;
  mvip_grant_s grant;
  mvip_level_e service_level;
  int fail_count = 0, checked = 0;
  int sh[9] = '{2, 3, 4, 5, 6, 13, 14, 15, 16};
  always #5 clk_sys = ~clk_sys;
  mvip_ctrl i_dut (.*);
  mvip_core_model i_core (.*);
  task ck(input logic ok);
    checked++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED %0t mismatch", $time);
    end
  endtask : ck
  // One cycle of stimulus, then settle and sample.
  task step(input logic [NUM_SRC-1:0] e, input logic a, input logic r);
    @(posedge clk_sys);
    src_event <= e;
    accept <= a;
    leave <= r;
    @(posedge clk_sys);
    src_event <= '0;
    accept <= 0;
    leave <= 0;
    #1;
  endtask : step
  task t_shared;
    foreach (sh[k]) begin
      step(NUM_SRC'(1) << sh[k], 0, 0);
      ck(grant.req === 1'b1 && grant.addr === (k < 5 ? VEC_THIRD_ADDR : VEC_SEVENTH_ADDR));
      step('0, 1, 0);
      ck(service_level === MVIP_LVL_LOW && src_pending === '0);
      step('0, 0, 1);
    end
    $display("shared vectors done");
  endtask : t_shared
  task t_nest;
    @(posedge clk_sys);
    vec_level_upper <= 10'h011;
    step(28'h8000000, 0, 0);
    step('0, 1, 0);
    step(28'h0400000, 0, 0);
    ck(grant.req === 1'b0 && src_pending[22] === 1'b1);
    step(28'h0000403, 0, 0);
    ck(grant.idx === 4'h0 && grant.level === MVIP_LVL_HIGHEST);
    step('0, 1, 0);
    ck(service_level === MVIP_LVL_HIGHEST && grant.req === 1'b0);
    step('0, 0, 1);
    ck(grant.idx === 4'h4 && grant.level === MVIP_LVL_HIGH);
    step('0, 1, 0);
    step('0, 0, 1);
    step('0, 0, 1);
    ck(grant.idx === 4'h1 && service_level === MVIP_LVL_NONE);
    @(posedge clk_sys);
    vec_enable <= 10'h3fd;
    #1;
    ck(grant.idx === 4'h8 && src_pending[1] === 1'b1);
    @(posedge clk_sys);
    vec_enable <= '1;
    src_clear <= '1;
    @(posedge clk_sys);
    src_clear <= '0;
    #1;
    ck(src_pending === '0);
    $display("nesting done");
  endtask : t_nest
  task wrap_up;
    $display("checked %0d failed %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1;
    t_shared;
    t_nest;
    wrap_up;
  end
  // Watchdog well beyond the fewer than a hundred cycles the tests need.
  initial begin
    #50us;
    fail_count++;
    wrap_up;
  end
endmodule : tb_mvip_ctrl
